// [bbh_pkg.sv]
// Package with constants for the byte bus host port.
`default_nettype none
package bbh_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam logic [7:0] DATA_RST = 8'h00;
    // Cycles from taking a write to acknowledging it.
    localparam logic [1:0] WR_LAT = 2'h1;
    // Cycles from a read request to valid data on the bus.
    localparam logic [1:0] RD_LAT = 2'h1;
    // Pull-up drive after release: 10 ns figure, at least one cycle.
    localparam int PULLUP_NS = 10;
    localparam int CLK_NS = 100;
    localparam int PULLUP_CYC_I = (PULLUP_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [1:0] PULLUP_CYC = (PULLUP_CYC_I < 1) ? 2'h1 : PULLUP_CYC_I[1:0];
    typedef enum logic [4:0] {
        BBH_IDLE = 5'h01,
        BBH_READ = 5'h02,
        BBH_WRITE = 5'h04,
        BBH_ACK = 5'h08,
        BBH_RELEASE = 5'h10
    } bbh_state_t;
endpackage
`default_nettype wire

// [bbh_lat_timer.sv]
// Small down counter that pulses when a loaded count expires.
`default_nettype none
module bbh_lat_timer (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [1:0] count,
    output logic done
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] cnt_r;
    logic run_r;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 2'h0;
            run_r <= 1'b0;
        end else if (load) begin
            cnt_r <= count;
            run_r <= 1'b1;
        end else if (run_r) begin
            cnt_r <= cnt_r - 2'h1;
            run_r <= (cnt_r > 2'h1);
        end
    end
    assign done = run_r && (cnt_r == 2'h1);
endmodule
`default_nettype wire

// [bbh_port.sv]
// Device end of the non-multiplexed byte bus with acknowledge handshake.
`default_nettype none
module bbh_port (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic dev_select_n,
    input wire logic addr_strobe_in,
    input wire logic read_strobe,
    input wire logic write_strobe,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] byte_bus_lines_in,
    output logic [7:0] byte_bus_lines_out,
    output logic byte_bus_lines_oe,
    output logic transfer_ack_n,
    output logic transfer_ack_oe,
    input wire logic idle_clk_pol,
    input wire logic sampling_phase_sel,
    output logic serial_idle_level,
    output logic serial_sample_falling,
    output logic [7:0] core_addr,
    output logic core_wr,
    output logic core_rd,
    output logic [7:0] core_wdata,
    input wire logic [7:0] core_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------
    // The address strobe is tied high in this bus mode, so it only gates selection.
    wire selected = !dev_select_n && addr_strobe_in;
    wire rd_req = selected && read_strobe;
    wire wr_req = selected && write_strobe;
    wire access_gone = !selected || (!read_strobe && !write_strobe);

    bbh_pkg::bbh_state_t state_r, state_nxt;
    logic [7:0] rdata_r;
    logic [7:0] wdata_r;
    logic [7:0] addr_r;
    logic ack_r, ack_oe_r, dout_oe_r, wr_r, rd_r;
    logic [1:0] pull_r;
    logic is_read_r;
    logic tmr_load, tmr_done;
    logic [1:0] tmr_count;

    bbh_lat_timer u_timer (
        .clock(clock),
        .rst_n(rst_n),
        .load(tmr_load),
        .count(tmr_count),
        .done(tmr_done)
    );

    // ------------------------------------------------------------
    // Handshake sequencing
    // ------------------------------------------------------------
    // A read wins when both strobes are high; the write is then simply not taken.
    wire start_rd = (state_r == bbh_pkg::BBH_IDLE) && rd_req;
    wire start_wr = (state_r == bbh_pkg::BBH_IDLE) && wr_req && !rd_req;
    assign tmr_load = start_rd || start_wr;
    assign tmr_count = start_rd ? bbh_pkg::RD_LAT : bbh_pkg::WR_LAT;

    // A host that gives up before the acknowledge gets none; the machine still
    // passes through release so the pin ends at a known level.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            bbh_pkg::BBH_IDLE: begin
                if (start_rd) begin
                    state_nxt = bbh_pkg::BBH_READ;
                end else if (start_wr) begin
                    state_nxt = bbh_pkg::BBH_WRITE;
                end
            end
            bbh_pkg::BBH_READ, bbh_pkg::BBH_WRITE: begin
                if (access_gone) begin
                    state_nxt = bbh_pkg::BBH_RELEASE;
                end else if (tmr_done) begin
                    state_nxt = bbh_pkg::BBH_ACK;
                end
            end
            bbh_pkg::BBH_ACK: begin
                if (access_gone) begin
                    state_nxt = bbh_pkg::BBH_RELEASE;
                end
            end
            bbh_pkg::BBH_RELEASE: begin
                if (pull_r == 2'h1) begin
                    state_nxt = bbh_pkg::BBH_IDLE;
                end
            end
            default: state_nxt = bbh_pkg::BBH_IDLE;
        endcase
    end

    // Read data is latched on the same edge that lowers the acknowledge, so the
    // byte is already on the bus when the host sees the handshake.
    wire rd_capture = (state_r == bbh_pkg::BBH_READ) && tmr_done;
    wire wr_capture = start_wr;
    wire ack_set = (state_nxt == bbh_pkg::BBH_ACK);
    wire in_release = (state_nxt == bbh_pkg::BBH_RELEASE);
    wire release_start = in_release && (state_r != bbh_pkg::BBH_RELEASE);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= bbh_pkg::BBH_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------
    // Data path
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= bbh_pkg::DATA_RST;
            wdata_r <= bbh_pkg::DATA_RST;
            addr_r <= bbh_pkg::DATA_RST;
            wr_r <= 1'b0;
            rd_r <= 1'b0;
        end else begin
            rd_r <= start_rd;
            wr_r <= wr_capture;
            if (tmr_load) begin
                addr_r <= addr_in;
            end
            if (wr_capture) begin
                wdata_r <= byte_bus_lines_in;
            end
            if (rd_capture) begin
                rdata_r <= core_rdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Access type
    // ------------------------------------------------------------
    // Remembers whether the current access is a read, so the bus is only driven then.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            is_read_r <= 1'b0;
        end else if (tmr_load) begin
            is_read_r <= start_rd;
        end
    end

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    // The acknowledge is open drain: driven low while acking, then driven high for
    // one cycle as the active pull-up, then left to the external resistor.
    // A whole cycle of pull-up is longer than the pin needs, but it keeps the
    // release timed by the one clock without any faster strobe.
    wire ack_n_nxt = !ack_set;
    wire ack_oe_nxt = ack_set || in_release;
    wire dout_oe_nxt = ack_set && is_read_r;
    wire [1:0] pull_nxt = release_start ? bbh_pkg::PULLUP_CYC
        : (pull_r != 2'h0) ? pull_r - 2'h1 : pull_r;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ack_r <= 1'b1;
            ack_oe_r <= 1'b0;
            dout_oe_r <= 1'b0;
        end else begin
            ack_r <= ack_n_nxt;
            ack_oe_r <= ack_oe_nxt;
            dout_oe_r <= dout_oe_nxt;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pull_r <= 2'h0;
        end else begin
            pull_r <= pull_nxt;
        end
    end

    // ------------------------------------------------------------
    // Serial mode straps
    // ------------------------------------------------------------
    // The straps only set levels here; they are registered so that these outputs
    // come from flip-flops like every other pin.
    logic idle_r, phase_r;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            idle_r <= 1'b0;
            phase_r <= 1'b0;
        end else begin
            idle_r <= idle_clk_pol;
            phase_r <= sampling_phase_sel;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign byte_bus_lines_out = rdata_r;
    assign byte_bus_lines_oe = dout_oe_r;
    assign transfer_ack_n = ack_r;
    assign transfer_ack_oe = ack_oe_r;
    assign serial_idle_level = idle_r;
    assign serial_sample_falling = phase_r;
    assign core_addr = addr_r;
    assign core_wr = wr_r;
    assign core_rd = rd_r;
    assign core_wdata = wdata_r;
endmodule
`default_nettype wire

// [bbh_props.sv]
// Checker for the byte bus host port.
`default_nettype none
module bbh_props (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic dev_select_n,
    input wire logic read_strobe,
    input wire logic write_strobe,
    input wire logic [7:0] byte_bus_lines_out,
    input wire logic byte_bus_lines_oe,
    input wire logic transfer_ack_n,
    input wire logic transfer_ack_oe,
    input wire logic idle_clk_pol,
    input wire logic serial_idle_level,
    input wire logic core_rd,
    input wire logic core_wr,
    input wire logic [7:0] core_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    a_rd_ack_data: assert property (core_rd && !dev_select_n && read_strobe
        |=> !transfer_ack_n && byte_bus_lines_oe
        && byte_bus_lines_out == $past(core_rdata)) else $error("bad read ack");
    a_wr_ack: assert property (core_wr && !dev_select_n && write_strobe
        |=> !transfer_ack_n && !byte_bus_lines_oe)
        else $error("bad write ack");
    a_sel_gate: assert property ((core_rd || core_wr) |-> !$past(dev_select_n))
        else $error("access while unselected");
    a_ack_release: assert property (!transfer_ack_n && !read_strobe && !write_strobe
        |=> transfer_ack_n && transfer_ack_oe ##1 !transfer_ack_oe) else $error("bad release");
    a_ack_driven: assert property (!transfer_ack_n |-> transfer_ack_oe)
        else $error("ack undriven");
    a_bus_owner: assert property (byte_bus_lines_oe |-> !transfer_ack_n)
        else $error("bus driven outside ack");
    a_one_pulse: assert property (core_rd |=> !core_rd [*2])
        else $error("read pulse too long");
    a_idle_level: assert property (serial_idle_level == $past(idle_clk_pol))
        else $error("idle level wrong");
    c_read: cover property (core_rd ##1 !transfer_ack_n);
    c_write: cover property (core_wr ##1 !transfer_ack_n);
    c_release: cover property ($rose(transfer_ack_n) ##1 !transfer_ack_oe);
endmodule
bind bbh_port bbh_props u_props (.clock(clock), .rst_n(rst_n), .dev_select_n(dev_select_n),
    .read_strobe(read_strobe), .write_strobe(write_strobe), .core_rdata(core_rdata),
    .byte_bus_lines_out(byte_bus_lines_out), .byte_bus_lines_oe(byte_bus_lines_oe),
    .transfer_ack_n(transfer_ack_n), .transfer_ack_oe(transfer_ack_oe), .core_rd(core_rd),
    .idle_clk_pol(idle_clk_pol), .serial_idle_level(serial_idle_level), .core_wr(core_wr));
`default_nettype wire

// [bbh_host.sv]
// Host CPU model for the byte bus.
`default_nettype none
module bbh_host (
    input wire logic clock,
    input wire logic [7:0] byte_bus_lines_out,
    input wire logic byte_bus_lines_oe,
    input wire logic transfer_ack_n,
    input wire logic transfer_ack_oe,
    output logic dev_select_n,
    output logic addr_strobe_in,
    output logic read_strobe,
    output logic write_strobe,
    output logic [7:0] addr_in,
    output logic [7:0] byte_bus_lines_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] wdata = 8'h00;
    logic [7:0] last_r = 8'h00;
    logic drive = 1'b0;
    logic ack;
    // A released bus must not look like a held copy of its last value.
    assign byte_bus_lines_in = byte_bus_lines_oe ? byte_bus_lines_out : drive ? wdata : ~last_r;
    assign ack = transfer_ack_oe ? transfer_ack_n : 1'b1;
    always @(posedge clock) last_r <= byte_bus_lines_in;
    initial begin
        dev_select_n = 1'b1;
        addr_strobe_in = 1'b1;
        read_strobe = 1'b0;
        write_strobe = 1'b0;
        addr_in = 8'h00;
    end
    task automatic access(input logic s, input logic w, input logic [7:0] a,
        input logic [7:0] d, output logic [7:0] q, output logic ok);
        ok = 1'b0;
        @(negedge clock);
        dev_select_n = !s;
        addr_in = a;
        wdata = d;
        drive = w;
        read_strobe = !w;
        write_strobe = w;
        for (int i = 0; i < 8 && !ok; i++) begin
            @(posedge clock);
            ok = !ack;
        end
        q = byte_bus_lines_in;
        @(negedge clock);
        dev_select_n = 1'b1;
        read_strobe = 1'b0;
        write_strobe = 1'b0;
        drive = 1'b0;
        repeat (3) @(negedge clock);
    endtask
endmodule
`default_nettype wire

// [byte_bus_host_port_handshake_bench.sv]
// Testbench for the byte bus host port.
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module byte_bus_host_port_handshake_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic icp = 1'b0;
    logic phs = 1'b0;
    logic sel_n, as_in, rd, wr, bus_oe, ack_n, ack_oe, lvl, fall, c_wr, c_rd, ok;
    logic [7:0] addr, bus_in, bus_out, c_addr, c_wdata, q;
    logic [15:0] wr_seen = 16'h0000;
    logic [3:0] n_rd = 4'h0;
    logic sclk_m = 1'b0;
    int n_errors = 0;
    int compares = 0;
    always #50 clock = ~clock;
    always @(posedge clock) if (c_wr) wr_seen <= {c_addr, c_wdata};
    always @(posedge clock) if (c_rd) n_rd <= n_rd + 4'h1;
    bbh_port DUT (.clock(clock), .rst_n(rst_n), .dev_select_n(sel_n), .addr_strobe_in(as_in),
        .read_strobe(rd), .write_strobe(wr), .addr_in(addr), .byte_bus_lines_in(bus_in),
        .byte_bus_lines_out(bus_out), .byte_bus_lines_oe(bus_oe), .transfer_ack_n(ack_n),
        .transfer_ack_oe(ack_oe), .idle_clk_pol(icp), .sampling_phase_sel(phs),
        .serial_idle_level(lvl), .serial_sample_falling(fall), .core_addr(c_addr),
        .core_wr(c_wr), .core_rd(c_rd), .core_wdata(c_wdata), .core_rdata(~c_addr));
    bbh_host host (.clock(clock), .byte_bus_lines_out(bus_out), .byte_bus_lines_oe(bus_oe),
        .transfer_ack_n(ack_n), .transfer_ack_oe(ack_oe), .dev_select_n(sel_n),
        .addr_strobe_in(as_in), .read_strobe(rd), .write_strobe(wr), .addr_in(addr),
        .byte_bus_lines_in(bus_in));
    task automatic print_verdict;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic xfer(input logic s, input logic w, input logic [7:0] a, input logic [7:0] d);
        host.access(s, w, a, d, q, ok);
        `CHK(ok, s)
        if (s && !ok) print_verdict();
    endtask
    task automatic t_write;
        xfer(1'b1, 1'b1, 8'h12, 8'ha5);
        `CHK(wr_seen, 16'h12a5)
    endtask
    task automatic t_read;
        xfer(1'b1, 1'b0, 8'h34, 8'h00);
        `CHK(q, 8'hcb)
        xfer(1'b1, 1'b0, 8'hff, 8'h00);
        `CHK(q, 8'h00)
        `CHK(ack_n, 1'b1)
        `CHK(ack_oe, 1'b0)
        `CHK(bus_oe, 1'b0)
        `CHK(n_rd, 4'h2)
    endtask
    task automatic t_unselected;
        xfer(1'b0, 1'b1, 8'h56, 8'h77);
        `CHK(wr_seen, 16'h12a5)
        `CHK(n_rd, 4'h2)
    endtask
    task automatic t_serial;
        for (int i = 0; i < 4; i++) begin
            @(negedge clock);
            {icp, phs} = i[1:0];
            sclk_m = i[1];
            repeat (2) @(negedge clock);
            `CHK({lvl, fall}, i[1:0])
            `CHK(lvl, sclk_m)
        end
    endtask
    initial begin
        repeat (20) @(negedge clock);
        rst_n = 1'b1;
        t_write();
        t_read();
        t_unselected();
        t_serial();
        print_verdict();
    end
endmodule
`default_nettype wire
